/* File: logic/dat_cfg.svh */
`ifndef DAT_CFG_SVH
`define DAT_CFG_SVH
// ------------------------------------------------
// register offsets
// ------------------------------------------------
`define DAT_OFS_CTRL 8'h00
`define DAT_OFS_STAT 8'h01
`define DAT_OFS_ADDRCTL 8'h02
`define DAT_OFS_TRIG 8'h03
`define DAT_OFS_CNT_LO 8'h04
`define DAT_OFS_CNT_HI 8'h05
`define DAT_OFS_SRC0 8'h08
`define DAT_OFS_DST0 8'h0C
// ------------------------------------------------
// field positions, encodings, reset values
// ------------------------------------------------
`define DAT_CTRL_EN_BIT 7
`define DAT_CTRL_SWREQ_BIT 4
`define DAT_STAT_BUSY_BIT 7
`define DAT_STAT_PEND_BIT 6
`define DAT_SRC_RLD_LSB 6
`define DAT_SRC_STEP_LSB 4
`define DAT_DST_RLD_LSB 2
`define DAT_DST_STEP_LSB 0
`define DAT_STEP_INC 2'h1
`define DAT_STEP_DEC 2'h2
`define DAT_RLD_BLOCK 2'h1
`define DAT_RLD_BURST 2'h2
`define DAT_RLD_TRANS 2'h3
`define DAT_RST_ADDRCTL 8'h00
`define DAT_RST_TRIG 8'h00
`define DAT_RST_CNT 16'h0000
// ------------------------------------------------
// trigger base values and offsets
// ------------------------------------------------
`define DAT_TRIG_OFF 8'h00
`define DAT_TB_EVT 8'h01
`define DAT_TB_AES 8'h04
`define DAT_TB_ADC_A 8'h10
`define DAT_TB_DAC_A 8'h15
`define DAT_TB_GRP_STRIDE 8'h10
`define DAT_TB_PORT_C 8'h40
`define DAT_TB_PORT_STRIDE 8'h20
`define DAT_TO_TC1 8'h06
`define DAT_TO_SPI 8'h0A
`define DAT_TO_USART0 8'h0B
`define DAT_TO_USART1 8'h0E
`define DAT_TO_ADC_ANY 8'h04
`endif

/* File: logic/dat_pkg.sv */
package dat_pkg;
    // request lines, grouped per unit
    typedef struct packed {
        logic [2:0] evt;
        logic aes;
        logic [1:0][3:0] adc;
        logic [1:0][1:0] dac;
        logic [3:0][5:0] tc0;
        logic [3:0][3:0] tc1;
        logic [3:0] spi;
        logic [3:0][1:0][1:0] usart;
    } dat_req_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } dat_bus_req_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ARMED,
        ST_BURST
    } dat_state_t;
endpackage : dat_pkg

/* File: logic/dat_trig_mux.sv */
`timescale 1ns/1ns
`include "dat_cfg.svh"
module dat_trig_mux #(
    parameter int NUM_PORTS = 4,
    parameter bit HAS_GRP_B = 1'b1
) (
    input wire logic [7:0] sel_i,
    input wire dat_pkg::dat_req_t req_i,
    output logic hit_o
);
    logic [255:0] map;

    if (NUM_PORTS < 1 || NUM_PORTS > 4) begin : g_chk
        $error("NUM_PORTS must be 1 to 4");
    end

    // ------------------------------------------------
    // trigger map: unmapped selects stay zero
    // ------------------------------------------------
    always_comb begin
        map = '0;
        for (int i = 0; i < 3; i++) begin
            map[8'(`DAT_TB_EVT + i)] = req_i.evt[i]; // [RULE_16]
        end
        map[`DAT_TB_AES] = req_i.aes; // [RULE_13]
        for (int g = 0; g < 2; g++) begin
            if (g == 0 || HAS_GRP_B) begin
                for (int c = 0; c < 4; c++) begin
                    map[8'(`DAT_TB_ADC_A + g * `DAT_TB_GRP_STRIDE + c)] = req_i.adc[g][c]; // [RULE_17]
                end
                map[8'(`DAT_TB_ADC_A + g * `DAT_TB_GRP_STRIDE + `DAT_TO_ADC_ANY)] = |req_i.adc[g]; // [RULE_17]
                for (int c = 0; c < 2; c++) begin
                    map[8'(`DAT_TB_DAC_A + g * `DAT_TB_GRP_STRIDE + c)] = req_i.dac[g][c]; // [RULE_18]
                end
            end
        end
        for (int p = 0; p < NUM_PORTS; p++) begin
            for (int t = 0; t < 6; t++) begin
                map[8'(`DAT_TB_PORT_C + p * `DAT_TB_PORT_STRIDE + t)] = req_i.tc0[p][t]; // [RULE_14] [RULE_19]
            end
            // timer one has no channel c or d
            for (int t = 0; t < 4; t++) begin
                map[8'(`DAT_TB_PORT_C + p * `DAT_TB_PORT_STRIDE + `DAT_TO_TC1 + t)] = req_i.tc1[p][t]; // [RULE_20]
            end
            map[8'(`DAT_TB_PORT_C + p * `DAT_TB_PORT_STRIDE + `DAT_TO_SPI)] = req_i.spi[p]; // [RULE_15]
            for (int k = 0; k < 2; k++) begin
                map[8'(`DAT_TB_PORT_C + p * `DAT_TB_PORT_STRIDE + `DAT_TO_USART0 + k)] = req_i.usart[p][0][k]; // [RULE_21]
                map[8'(`DAT_TB_PORT_C + p * `DAT_TB_PORT_STRIDE + `DAT_TO_USART1 + k)] = req_i.usart[p][1][k]; // [RULE_21]
            end
        end
        map[`DAT_TRIG_OFF] = 1'b0;
    end

    assign hit_o = map[sel_i]; // [RULE_09]
endmodule : dat_trig_mux

/* File: logic/dat_addr_gen.sv */
`timescale 1ns/1ns
`include "dat_cfg.svh"
module dat_addr_gen (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [2:0] wr_i,
    input wire logic [7:0] wdata_i,
    input wire logic [1:0] step_i,
    input wire logic [1:0] reload_i,
    input wire logic beat_i,
    input wire logic burst_end_i,
    input wire logic block_end_i,
    input wire logic trans_end_i,
    output logic [23:0] addr_o
);
    logic [23:0] init_q;
    logic [23:0] addr_q;
    logic do_reload;

    assign do_reload = (reload_i == `DAT_RLD_BLOCK && block_end_i) ||
                       (reload_i == `DAT_RLD_BURST && burst_end_i) ||
                       (reload_i == `DAT_RLD_TRANS && trans_end_i);

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            init_q <= 24'h000000;
            addr_q <= 24'h000000;
        end else if (|wr_i) begin
            for (int b = 0; b < 3; b++) begin
                if (wr_i[b]) begin
                    init_q[b*8 +: 8] <= wdata_i;
                    addr_q[b*8 +: 8] <= wdata_i;
                end
            end
        end else if (beat_i && do_reload) begin
            addr_q <= init_q; // [RULE_01] [RULE_05]
        end else if (beat_i && step_i == `DAT_STEP_INC) begin
            addr_q <= addr_q + 24'h000001; // [RULE_24]
        end else if (beat_i && step_i == `DAT_STEP_DEC) begin
            addr_q <= addr_q - 24'h000001; // [RULE_24]
        end
    end

    assign addr_o = addr_q;

    a_reload_init: assert property (@(posedge clk_i) disable iff (!nrst_i) // [RULE_01] [RULE_05]
        beat_i && do_reload && wr_i == 3'h0 |=> addr_q == $past(init_q))
        else $error("address not restored to initial value");
endmodule : dat_addr_gen

/* File: logic/dat_top.sv */
`timescale 1ns/1ns
`include "dat_cfg.svh"
// What this block does
// [RULE_01] source reload field 7:6 picks none, block, burst or transaction reload
// [RULE_02] source reload writes are ignored while the channel is busy
// [RULE_03] source step field 5:4: fixed, increment, decrement; 11 reserved
// [RULE_04] source step and destination fields are frozen while busy
// [RULE_05] destination reload field 3:2 works like the source reload
// [RULE_06] destination step field 1:0: fixed, increment, decrement; 11 reserved
// [RULE_07] trigger select picks the request line; zero means software only
// [RULE_08] software forms the select as unit base plus request offset
// [RULE_09] selects of absent units match no request
// [RULE_10] a request that falls before service is dropped
// [RULE_11] serving a request may clear the peripheral flag
// [RULE_12] the request is cleared by the access that serves it
// [RULE_13] bases: events 01, crypto 04, converters 10, 15, 20, 25
// [RULE_14] timer bases 40/46, 60/66, 80/86, A0/A6
// [RULE_15] serial bases: port base plus 0A, 0B and 0E
// [RULE_16] event offsets 0 to 2 pick event channels 0 to 2
// [RULE_17] converter offsets 0 to 3 per channel, 4 any channel
// [RULE_18] the analog output unit has offsets 0 and 1 only
// [RULE_19] timer offsets: 0 wrap, 1 error, 2 to 5 compare channels
// [RULE_20] compare channels c and d exist on timer zero only
// [RULE_21] serial offsets: 0 receive complete, 1 transmit empty
// [RULE_22] busy reads one from transaction start and gates field protection
// [RULE_23] 16-bit byte count steps down per byte and reloads on the byte where it reads one
// [RULE_24] addresses step by one per byte over the full 24 bits
module dat_top #(
    parameter int NUM_PORTS = 4,
    parameter bit HAS_GRP_B = 1'b1
) (
    input wire logic CLK_SYS_I,
    input wire logic NRST_I,
    input wire dat_pkg::dat_bus_req_t REG_REQ_I,
    output logic [7:0] REG_RDATA_O,
    input wire dat_pkg::dat_req_t REQ_I,
    output logic TRIG_ACK_O,
    output logic [7:0] TRIG_ID_O,
    output logic XFER_O,
    output logic [23:0] SRC_ADDR_O,
    output logic [23:0] DST_ADDR_O,
    output logic BUSY_O,
    output logic DONE_O
);
    dat_pkg::dat_state_t state_q;
    logic en_q;
    logic sw_pend_q;
    logic busy_q;
    logic done_q;
    logic [1:0] blen_q;
    logic [7:0] addrctl_q;
    logic [7:0] trig_q;
    logic [15:0] cnt_q;
    logic [15:0] cnt_init_q;
    logic [3:0] bcnt_q;
    logic [7:0] rdata_q;
    logic hw_hit;
    logic start;
    logic beat;
    logic block_last;
    logic burst_last;
    logic trans_end;
    logic [3:0] burst_max;
    logic [7:0] wa;
    logic wr;

    assign wa = REG_REQ_I.addr;
    assign wr = REG_REQ_I.wr;

    // ------------------------------------------------
    // trigger selection
    // ------------------------------------------------
    dat_trig_mux #(
        .NUM_PORTS(NUM_PORTS),
        .HAS_GRP_B(HAS_GRP_B)
    ) u_mux (
        .sel_i(trig_q),
        .req_i(REQ_I),
        .hit_o(hw_hit)
    );

    // requests are sampled live, never latched, so a fallen line is lost
    // en_q gates start: a disable written while armed must not serve, nor acknowledge, a request
    assign start = state_q == dat_pkg::ST_ARMED && en_q && (hw_hit || sw_pend_q); // [RULE_07] [RULE_10]
    assign beat = state_q == dat_pkg::ST_BURST;
    assign block_last = cnt_q == 16'h0001;
    assign burst_max = 4'((5'h01 << blen_q) - 5'h01);
    assign burst_last = block_last || bcnt_q == burst_max;
    assign trans_end = beat && block_last;
    // serving access: the peripheral drops its flag on this pulse
    assign TRIG_ACK_O = start && !sw_pend_q && hw_hit; // [RULE_11] [RULE_12]

    // ------------------------------------------------
    // control register
    // ------------------------------------------------
    always_ff @(posedge CLK_SYS_I) begin
        if (!NRST_I) begin
            en_q <= 1'b0;
            blen_q <= 2'h0;
        end else if (wr && wa == `DAT_OFS_CTRL) begin
            en_q <= REG_REQ_I.wdata[`DAT_CTRL_EN_BIT];
            blen_q <= REG_REQ_I.wdata[1:0];
        end else if (trans_end) begin
            en_q <= 1'b0;
        end
    end

    // a new software request in the start cycle survives the clear
    always_ff @(posedge CLK_SYS_I) begin
        if (!NRST_I) begin
            sw_pend_q <= 1'b0;
        end else if (wr && wa == `DAT_OFS_CTRL && REG_REQ_I.wdata[`DAT_CTRL_SWREQ_BIT]) begin
            sw_pend_q <= REG_REQ_I.wdata[`DAT_CTRL_EN_BIT];
        end else if (start || !en_q) begin
            sw_pend_q <= 1'b0;
        end
    end

    // ------------------------------------------------
    // channel sequence
    // ------------------------------------------------
    always_ff @(posedge CLK_SYS_I) begin
        if (!NRST_I) begin
            state_q <= dat_pkg::ST_IDLE;
        end else begin
            case (state_q)
                dat_pkg::ST_IDLE: begin
                    if (en_q) begin
                        state_q <= dat_pkg::ST_ARMED;
                    end
                end
                dat_pkg::ST_ARMED: begin
                    if (!en_q) begin
                        state_q <= dat_pkg::ST_IDLE;
                    end else if (start) begin
                        state_q <= dat_pkg::ST_BURST;
                    end
                end
                dat_pkg::ST_BURST: begin
                    if (!en_q || trans_end) begin
                        state_q <= dat_pkg::ST_IDLE;
                    end else if (burst_last) begin
                        state_q <= dat_pkg::ST_ARMED;
                    end
                end
                default: begin
                    state_q <= dat_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (!NRST_I) begin
            bcnt_q <= 4'h0;
        end else if (beat && !burst_last) begin
            bcnt_q <= bcnt_q + 4'h1;
        end else begin
            bcnt_q <= 4'h0;
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (!NRST_I) begin
            busy_q <= 1'b0;
        end else if (trans_end || !en_q) begin
            busy_q <= 1'b0;
        end else if (start) begin
            busy_q <= 1'b1; // [RULE_22]
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (!NRST_I) begin
            done_q <= 1'b0;
        end else begin
            done_q <= trans_end;
        end
    end

    // ------------------------------------------------
    // addressing and trigger registers
    // ------------------------------------------------
    always_ff @(posedge CLK_SYS_I) begin
        if (!NRST_I) begin
            addrctl_q <= `DAT_RST_ADDRCTL;
        end else if (wr && wa == `DAT_OFS_ADDRCTL && !busy_q) begin
            addrctl_q <= REG_REQ_I.wdata; // [RULE_02] [RULE_04]
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (!NRST_I) begin
            trig_q <= `DAT_RST_TRIG;
        end else if (wr && wa == `DAT_OFS_TRIG) begin
            trig_q <= REG_REQ_I.wdata;
        end
    end

    // ------------------------------------------------
    // block byte count
    // ------------------------------------------------
    always_ff @(posedge CLK_SYS_I) begin
        if (!NRST_I) begin
            cnt_q <= `DAT_RST_CNT;
            cnt_init_q <= `DAT_RST_CNT;
        end else if (wr && wa == `DAT_OFS_CNT_LO) begin
            cnt_q[7:0] <= REG_REQ_I.wdata;
            cnt_init_q[7:0] <= REG_REQ_I.wdata;
        end else if (wr && wa == `DAT_OFS_CNT_HI) begin
            cnt_q[15:8] <= REG_REQ_I.wdata;
            cnt_init_q[15:8] <= REG_REQ_I.wdata;
        end else if (beat && block_last) begin
            cnt_q <= cnt_init_q; // [RULE_23]
        end else if (beat) begin
            cnt_q <= cnt_q - 16'h0001; // [RULE_23]
        end
    end

    // ------------------------------------------------
    // address generators
    // ------------------------------------------------
    logic [2:0] src_wr;
    logic [2:0] dst_wr;

    for (genvar b = 0; b < 3; b++) begin : g_wr
        assign src_wr[b] = wr && wa == 8'(`DAT_OFS_SRC0 + b);
        assign dst_wr[b] = wr && wa == 8'(`DAT_OFS_DST0 + b);
    end

    dat_addr_gen u_src (
        .clk_i(CLK_SYS_I),
        .nrst_i(NRST_I),
        .wr_i(src_wr),
        .wdata_i(REG_REQ_I.wdata),
        .step_i(addrctl_q[`DAT_SRC_STEP_LSB +: 2]), // [RULE_03]
        .reload_i(addrctl_q[`DAT_SRC_RLD_LSB +: 2]), // [RULE_01]
        .beat_i(beat),
        .burst_end_i(beat && burst_last),
        .block_end_i(beat && block_last),
        .trans_end_i(trans_end),
        .addr_o(SRC_ADDR_O)
    );

    dat_addr_gen u_dst (
        .clk_i(CLK_SYS_I),
        .nrst_i(NRST_I),
        .wr_i(dst_wr),
        .wdata_i(REG_REQ_I.wdata),
        .step_i(addrctl_q[`DAT_DST_STEP_LSB +: 2]), // [RULE_06]
        .reload_i(addrctl_q[`DAT_DST_RLD_LSB +: 2]), // [RULE_05]
        .beat_i(beat),
        .burst_end_i(beat && burst_last),
        .block_end_i(beat && block_last),
        .trans_end_i(trans_end),
        .addr_o(DST_ADDR_O)
    );

    // ------------------------------------------------
    // read port: data one cycle after the strobe
    // ------------------------------------------------
    always_ff @(posedge CLK_SYS_I) begin
        if (!NRST_I) begin
            rdata_q <= 8'h00;
        end else if (REG_REQ_I.rd) begin
            case (wa)
                `DAT_OFS_CTRL: rdata_q <= {en_q, 3'h0, sw_pend_q, 1'b0, blen_q};
                `DAT_OFS_STAT: rdata_q <= {busy_q, sw_pend_q || (hw_hit && en_q), 6'h00};
                `DAT_OFS_ADDRCTL: rdata_q <= addrctl_q;
                `DAT_OFS_TRIG: rdata_q <= trig_q;
                `DAT_OFS_CNT_LO: rdata_q <= cnt_q[7:0];
                `DAT_OFS_CNT_HI: rdata_q <= cnt_q[15:8];
                8'h08: rdata_q <= SRC_ADDR_O[7:0];
                8'h09: rdata_q <= SRC_ADDR_O[15:8];
                8'h0A: rdata_q <= SRC_ADDR_O[23:16];
                8'h0C: rdata_q <= DST_ADDR_O[7:0];
                8'h0D: rdata_q <= DST_ADDR_O[15:8];
                8'h0E: rdata_q <= DST_ADDR_O[23:16];
                default: rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign REG_RDATA_O = rdata_q;
    assign TRIG_ID_O = trig_q;
    assign XFER_O = beat;
    assign BUSY_O = busy_q;
    assign DONE_O = done_q;

    // ------------------------------------------------
    // checks
    // ------------------------------------------------
    sequence s_ctl_write_busy;
        busy_q && wr && wa == `DAT_OFS_ADDRCTL;
    endsequence

    sequence s_one_byte_burst;
        beat ##1 !beat;
    endsequence

    a_src_reload_held: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I) // [RULE_02]
        s_ctl_write_busy |=> addrctl_q[7:6] == $past(addrctl_q[7:6]))
        else $error("source reload changed while busy");

    a_fields_held: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I) // [RULE_04]
        s_ctl_write_busy |=> $stable(addrctl_q[5:0]))
        else $error("address fields changed while busy");

    a_trig_off_quiet: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I) // [RULE_07]
        state_q == dat_pkg::ST_ARMED && trig_q == `DAT_TRIG_OFF && !sw_pend_q |=> !beat)
        else $error("transfer started with triggers off");

    a_drop_no_start: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I) // [RULE_10]
        state_q == dat_pkg::ST_ARMED && !hw_hit && !sw_pend_q |=> state_q != dat_pkg::ST_BURST)
        else $error("burst without a live request");

    a_ack_then_burst: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I) // [RULE_12]
        TRIG_ACK_O |=> beat && busy_q)
        else $error("served request not followed by a transfer");

    a_busy_on_start: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I) // [RULE_22]
        start |=> busy_q throughout (beat [*1]))
        else $error("busy not raised at transaction start");

    a_count_steps: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I) // [RULE_23]
        beat && !block_last && !wr |=> cnt_q == $past(cnt_q) - 16'h0001)
        else $error("byte count did not step down");

    a_count_reload: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I) // [RULE_23]
        beat && block_last && !wr |=> cnt_q == cnt_init_q && !busy_q && DONE_O)
        else $error("byte count not reloaded at block end");

    a_src_inc: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I) // [RULE_03] [RULE_24]
        beat && !burst_last && addrctl_q[7:4] == 4'h1 && !wr
        |=> SRC_ADDR_O == $past(SRC_ADDR_O) + 24'h000001)
        else $error("source address did not increment");

    a_dst_dec: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I) // [RULE_06] [RULE_24]
        beat && !burst_last && addrctl_q[3:0] == 4'h2 && !wr
        |=> DST_ADDR_O == $past(DST_ADDR_O) - 24'h000001)
        else $error("destination address did not decrement");

    a_single_burst: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
        start && blen_q == 2'h0 && en_q && !wr |=> s_one_byte_burst)
        else $error("one-byte burst ran longer");
endmodule : dat_top

/* File: dv/dat_periph_model.sv */
`timescale 1ns/1ns
// ------------------------------------------------
// request flags of the peripherals and events
// ------------------------------------------------
module dat_periph_model (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [75:0] set_i,
    input wire logic drop_i,
    input wire logic ack_i,
    output dat_pkg::dat_req_t req_o
);
    logic [75:0] flags_q;
    // the serving access clears every flag, so a pending interrupt is lost too
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            flags_q <= '0;
        end else if (drop_i || ack_i) begin
            flags_q <= '0;
        end else begin
            flags_q <= flags_q | set_i;
        end
    end
    assign req_o = flags_q;
endmodule : dat_periph_model

/* File: dv/dat_top_tb.sv */
`timescale 1ns/1ns
module dat_top_tb;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    dat_pkg::dat_bus_req_t reg_req = '0;
    logic [75:0] set_mask = '0;
    logic drop = 1'b0;
    dat_pkg::dat_req_t req;
    logic [7:0] rdata;
    logic [7:0] trig_id;
    logic ack, xfer, busy, done, hit;
    logic [23:0] src, dst;
    logic [23:0] sq[$];
    logic [23:0] dq[$];
    int failures = 0;
    int samples_checked = 0;
    // select = unit base plus request offset; then flag index, then expected hit
    localparam logic [15:0] ROWS [21] = '{
        {8'h01, 7'h49, 1'h1}, {8'h03, 7'h4B, 1'h1}, {8'h04, 7'h48, 1'h1}, {8'h13, 7'h43, 1'h1},
        {8'h14, 7'h41, 1'h1}, {8'h16, 7'h3D, 1'h1}, {8'h17, 7'h3D, 1'h0}, {8'h25, 7'h3E, 1'h1},
        {8'h20, 7'h44, 1'h1}, {8'h40, 7'h24, 1'h1}, {8'h45, 7'h29, 1'h1}, {8'h46, 7'h14, 1'h1},
        {8'h4A, 7'h10, 1'h1}, {8'h4B, 7'h00, 1'h1}, {8'h4F, 7'h03, 1'h1}, {8'h6B, 7'h04, 1'h1},
        {8'hA5, 7'h3B, 1'h1}, {8'hA9, 7'h23, 1'h1}, {8'h8E, 7'h0A, 1'h1}, {8'h00, 7'h49, 1'h0},
        {8'hC0, 7'h24, 1'h0}};
    always #5 clk_sys = ~clk_sys;
    dat_top DUT (.CLK_SYS_I(clk_sys), .NRST_I(nrst), .REG_REQ_I(reg_req), .REG_RDATA_O(rdata),
        .REQ_I(req), .TRIG_ACK_O(ack), .TRIG_ID_O(trig_id), .XFER_O(xfer), .SRC_ADDR_O(src),
        .DST_ADDR_O(dst), .BUSY_O(busy), .DONE_O(done));
    dat_periph_model periph (.clk_i(clk_sys), .nrst_i(nrst), .set_i(set_mask), .drop_i(drop),
        .ack_i(ack), .req_o(req));
    // ------------------------------------------------
    // shared tasks
    // ------------------------------------------------
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        reg_req.wr <= 1'b0;
    endtask : reg_wr
    task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        reg_req.rd <= 1'b0;
        #1;
        chk({16'h0000, rdata}, {16'h0000, exp});
    endtask : reg_rd
    task automatic pulse(input logic [75:0] m, input logic d);
        @(posedge clk_sys);
        set_mask <= m;
        drop <= d;
        @(posedge clk_sys);
        set_mask <= '0;
        drop <= 1'b0;
    endtask : pulse
    // watches a span of cycles for a served request, a finish and the byte addresses;
    // called at a clock edge, it samples just after that edge so a one-cycle serve pulse is seen
    task automatic watch(input int n);
        hit = 1'b0;
        repeat (n) begin
            #1;
            if (ack === 1'b1) hit = 1'b1;
            if (xfer === 1'b1) begin
                sq.push_back(src);
                dq.push_back(dst);
            end
            if (done === 1'b1) break;
            @(posedge clk_sys);
        end
    endtask : watch
    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done
    // ------------------------------------------------
    // main sequence
    // ------------------------------------------------
    initial begin
        repeat (20) @(posedge clk_sys);
        nrst <= 1'b1;
        reg_rd(8'h02, 8'h00);
        reg_rd(8'h03, 8'h00);
        chk({23'h0, busy}, 24'h0);
        $display("test reset done");
        foreach (ROWS[i]) begin
            reg_wr(8'h03, ROWS[i][15:8]);
            reg_wr(8'h04, 8'h01);
            reg_wr(8'h05, 8'h00);
            reg_wr(8'h00, 8'h80);
            pulse(76'h1 << ROWS[i][7:1], 1'b0);
            watch(12);
            chk({23'h0, hit}, {23'h0, ROWS[i][0]});
            chk({23'h0, hit}, {23'h0, ROWS[i][0]});
            chk({16'h0, trig_id}, {16'h0, ROWS[i][15:8]});
            reg_wr(8'h00, 8'h00);
            pulse('0, 1'b1);
        end
        $display("test trigger table done");
        reg_wr(8'h03, 8'h00);
        reg_wr(8'h00, 8'h80);
        pulse(76'h1 << 36, 1'b0);
        pulse('0, 1'b1);
        reg_wr(8'h03, 8'h40);
        watch(8);
        chk({23'h0, hit}, 24'h0);
        reg_wr(8'h00, 8'h00);
        $display("test dropped request done");
        reg_wr(8'h02, 8'h12);
        reg_wr(8'h08, 8'hFF);
        reg_wr(8'h09, 8'hFF);
        reg_wr(8'h0A, 8'hFF);
        reg_wr(8'h0C, 8'h10);
        reg_wr(8'h0D, 8'h00);
        reg_wr(8'h0E, 8'h00);
        reg_wr(8'h04, 8'h02);
        sq.delete();
        dq.delete();
        reg_wr(8'h00, 8'h91);
        watch(12);
        chk({23'h0, done}, 24'h1);
        chk(sq.size(), 24'h2);
        if (sq.size() == 2) begin
            chk(sq[0], 24'hFFFFFF);
            chk(sq[1], 24'h000000);
            chk(dq[0], 24'h000010);
            chk(dq[1], 24'h00000F);
        end
        $display("test stepping done");
        reg_wr(8'h02, 8'hD5);
        reg_wr(8'h0C, 8'h20);
        reg_wr(8'h00, 8'h90);
        repeat (4) @(posedge clk_sys);
        #1;
        chk({23'h0, busy}, 24'h1);
        reg_wr(8'h02, 8'h00);
        reg_rd(8'h02, 8'hD5);
        reg_wr(8'h00, 8'h90);
        watch(12);
        @(posedge clk_sys);
        #1;
        chk(src, 24'hFFFFFF);
        chk(dst, 24'h000020);
        chk({23'h0, busy}, 24'h0);
        $display("test reload and protection done");
        test_done();
    end
    initial begin
        #300000;
        failures++;
        test_done();
    end
endmodule : dat_top_tb
